//--- rtl/ssp_port.sv
// byte serial port: apb registers, shifter, flags, rate divider
`timescale 1ns/100ps
`default_nettype none
module ssp_port (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic dma_wr_en,
  input wire logic [7:0] dma_wdata,
  input wire logic dma_rd_en,
  output logic [7:0] dma_rdata,
  output logic tx_cpu_irq,
  output logic tx_dma_req,
  output logic rx_cpu_irq,
  output logic rx_dma_req,
  output logic err_cpu_irq,
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe,
  input wire logic mosi_i,
  output logic mosi_o,
  output logic mosi_oe,
  input wire logic miso_i,
  output logic miso_o,
  output logic miso_oe,
  input wire logic ss_n_i,
  output logic ss_owned,
  output logic ss_gpio_free
);
  // ==========================================================
  // registers
  logic [7:0] ctrl_r;
  logic [1:0] rate_r;
  logic fen_r;
  logic errie_r;
  logic txe_r;
  logic rxf_r;
  logic ovr_r;
  logic mode_fault_flag_r;
  logic rf_arm_r;
  logic mf_arm_r;
  logic [7:0] tx_hold_r;
  logic [7:0] rx_hold_r;
  logic [7:0] sh_r;
  logic [7:0] rsh_r;
  logic [7:0] rsh_nxt;
  logic [3:0] edge_r;
  logic [6:0] cnt_r;
  logic [6:0] half;
  logic sck_ph_r;
  logic sck_q_r;
  ssp_pkg::ssp_state_t st_r;

  logic en;
  logic mstr;
  logic dma_route_select;
  logic cpha;
  logic acc;
  logic wr;
  logic rd;
  logic hit_ctrl;
  logic hit_stat;
  logic hit_data;
  logic cpu_wr_data;
  logic cpu_rd_data;
  logic rd_stat;
  logic data_rd;
  logic start;
  logic tick;
  logic edge_ev;
  logic lead;
  logic samp;
  logic shft;
  logic done;
  logic din;
  logic fault_m;
  logic fault_s;
  logic fault;

  assign en = ctrl_r[ssp_pkg::C_EN];
  assign mstr = ctrl_r[ssp_pkg::C_MSTR];
  assign dma_route_select = ctrl_r[ssp_pkg::C_DMA_ROUTE_SELECT];
  assign cpha = ctrl_r[ssp_pkg::C_CPHA];

  // ==========================================================
  // apb slave, zero wait states
  assign acc = psel & penable & ce;
  assign wr = acc & pwrite;
  assign rd = acc & ~pwrite;
  assign hit_ctrl = paddr[7:2] == ssp_pkg::IDX_CTRL;
  assign hit_stat = paddr[7:2] == ssp_pkg::IDX_STAT;
  assign hit_data = paddr[7:2] == ssp_pkg::IDX_DATA;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~(hit_ctrl | hit_stat | hit_data);
  assign cpu_wr_data = wr & hit_data;
  assign cpu_rd_data = rd & hit_data;
  assign rd_stat = rd & hit_stat;
  assign data_rd = cpu_rd_data | (dma_rd_en & ce);

  always_comb
  begin
    prdata = 32'h0;
    if (hit_ctrl)
      prdata[7:0] = ctrl_r;
    else if (hit_stat)
      prdata[7:0] = {rxf_r, errie_r, ovr_r, mode_fault_flag_r, txe_r, fen_r, rate_r};
    else if (hit_data)
      prdata[7:0] = rx_hold_r;
  end

  // control register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_r <= ssp_pkg::CTRL_RST;
    else if (ce && wr && hit_ctrl)
      ctrl_r <= pwdata[7:0];
  end

  // writable fields of status and control
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rate_r <= ssp_pkg::RATE_RST;
      fen_r <= 1'b0;
      errie_r <= 1'b0;
    end
    else if (ce && wr && hit_stat)
    begin
      rate_r <= pwdata[1:0];
      fen_r <= pwdata[ssp_pkg::S_FEN];
      errie_r <= pwdata[ssp_pkg::S_ERRIE];
    end
  end

  // ==========================================================
  // transmit holding and empty flag
  always_ff @(posedge pclk)
  begin
    if (ce && cpu_wr_data)
      tx_hold_r <= pwdata[7:0];
    else if (ce && dma_wr_en)
      tx_hold_r <= dma_wdata;
  end

  // a master load never coincides with a write; a slave load of a full holding register wins over a write in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      txe_r <= 1'b1;
    else if (ce)
    begin
      if (start && !txe_r)
        txe_r <= 1'b1;
      else if (cpu_wr_data)
        txe_r <= 1'b0;
      else if (dma_wr_en)
        txe_r <= 1'b0;
    end
  end

  // ==========================================================
  // receive holding, full and overflow
  always_ff @(posedge pclk)
  begin
    if (ce && done && !rxf_r)
      rx_hold_r <= rsh_nxt;
  end

  assign dma_rdata = rx_hold_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rf_arm_r <= 1'b0;
    else if (ce)
    begin
      if (rd_stat)
        rf_arm_r <= rxf_r | ovr_r;
      else if (cpu_rd_data)
        rf_arm_r <= 1'b0;
    end
  end

  // a clearing read wins over a new byte in the same cycle; the byte is dropped and overflow set
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rxf_r <= 1'b0;
    else if (ce)
    begin
      if (done && !rxf_r)
        rxf_r <= 1'b1;
      else if (dma_route_select ? data_rd : (cpu_rd_data && rf_arm_r))
        rxf_r <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ovr_r <= 1'b0;
    else if (ce)
    begin
      if (done && rxf_r)
        ovr_r <= 1'b1;
      else if (cpu_rd_data && rf_arm_r)
        ovr_r <= 1'b0;
    end
  end

  // ==========================================================
  // mode fault
  assign fault_m = en & mstr & ~ss_n_i;
  assign fault_s = en & ~mstr & (st_r == ssp_pkg::SSP_SHIFT) & ss_n_i;
  assign fault = fen_r & (fault_m | fault_s);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mf_arm_r <= 1'b0;
    else if (ce)
    begin
      if (rd_stat)
        mf_arm_r <= mode_fault_flag_r;
      else if (wr && hit_ctrl)
        mf_arm_r <= 1'b0;
    end
  end

  // only a status read then control write clears it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mode_fault_flag_r <= 1'b0;
    else if (ce)
    begin
      if (fault)
        mode_fault_flag_r <= 1'b1;
      else if (wr && hit_ctrl && mf_arm_r)
        mode_fault_flag_r <= 1'b0;
    end
  end

  // select pin ownership
  assign ss_owned = en & (~mstr | fen_r);
  assign ss_gpio_free = ~ss_owned;

  // ==========================================================
  // rate divider, master only
  always_comb
  begin
    case (rate_r)
      2'h0: half = ssp_pkg::HALF_00;
      2'h1: half = ssp_pkg::HALF_01;
      2'h2: half = ssp_pkg::HALF_10;
      2'h3: half = ssp_pkg::HALF_11;
      default: half = ssp_pkg::HALF_00;
    endcase
  end

  assign tick = mstr & (st_r == ssp_pkg::SSP_SHIFT) & (cnt_r == half - 7'h1);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_r <= 7'h0;
    else if (ce)
    begin
      if (start || tick || !mstr)
        cnt_r <= 7'h0;
      else if (st_r == ssp_pkg::SSP_SHIFT)
        cnt_r <= cnt_r + 7'h1;
    end
  end

  // ==========================================================
  // shifter sequencing
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sck_q_r <= 1'b0;
    else if (ce)
      sck_q_r <= sck_i;
  end

  // master waits for a full holding register; slave arms while selected
  always_comb
  begin
    start = 1'b0;
    if (en && st_r == ssp_pkg::SSP_IDLE && !fault)
    begin
      if (mstr)
        start = !txe_r && !cpu_wr_data && !dma_wr_en && !mode_fault_flag_r;
      else
        start = !ss_n_i;
    end
  end

  assign edge_ev = (st_r == ssp_pkg::SSP_SHIFT) &
                   (mstr ? tick : (sck_i ^ sck_q_r));
  assign lead = ~edge_r[0];
  assign samp = edge_ev & (cpha ? ~lead : lead);
  assign shft = edge_ev & ~samp & ~(cpha & (edge_r == 4'h0));
  assign done = edge_ev & (edge_r == ssp_pkg::LAST_EDGE);
  assign din = mstr ? miso_i : mosi_i;
  assign rsh_nxt = samp ? {rsh_r[6:0], din} : rsh_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_r <= ssp_pkg::SSP_IDLE;
    else if (ce)
    begin
      case (st_r)
        ssp_pkg::SSP_IDLE:
          if (start)
            st_r <= ssp_pkg::SSP_SHIFT;
        ssp_pkg::SSP_SHIFT:
          if (done || !en || fault || (!mstr && ss_n_i))
            st_r <= ssp_pkg::SSP_IDLE;
        default: st_r <= ssp_pkg::SSP_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      edge_r <= 4'h0;
    else if (ce)
    begin
      if (start)
        edge_r <= 4'h0;
      else if (edge_ev)
        edge_r <= edge_r + 4'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sck_ph_r <= 1'b0;
    else if (ce)
    begin
      if (start)
        sck_ph_r <= 1'b0;
      else if (tick)
        sck_ph_r <= ~sck_ph_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sh_r <= 8'h0;
      rsh_r <= 8'h0;
    end
    else if (ce)
    begin
      if (start)
        sh_r <= tx_hold_r;
      else if (shft)
        sh_r <= {sh_r[6:0], 1'b0};
      rsh_r <= start ? 8'h0 : rsh_nxt;
    end
  end

  // ==========================================================
  // pins and requests
  assign sck_o = ctrl_r[ssp_pkg::C_CPOL] ^ sck_ph_r;
  assign sck_oe = en & mstr;
  assign mosi_o = sh_r[7];
  assign mosi_oe = en & mstr;
  assign miso_o = sh_r[7];
  assign miso_oe = en & ~mstr & ~ss_n_i;

  assign tx_cpu_irq = txe_r & ctrl_r[ssp_pkg::C_TXIE] & ~dma_route_select;
  assign tx_dma_req = txe_r & ctrl_r[ssp_pkg::C_TXIE] & dma_route_select;
  assign rx_cpu_irq = rxf_r & ctrl_r[ssp_pkg::C_RXIE] & ~dma_route_select;
  assign rx_dma_req = rxf_r & ctrl_r[ssp_pkg::C_RXIE] & dma_route_select;
  assign err_cpu_irq = errie_r & (mode_fault_flag_r | ovr_r);

  // ==========================================================
  // checks
  a_txe_on_load: assert property (@(posedge pclk) disable iff (!presetn)
    ce && start && mstr && !txe_r |=> txe_r)
    else $error("tx empty not set on load");
  a_txe_cpu_clr: assert property (@(posedge pclk) disable iff (!presetn)
    ce && cpu_wr_data |=> !txe_r && tx_hold_r == $past(pwdata[7:0]))
    else $error("cpu write did not fill tx");
  a_txe_dma_clr: assert property (@(posedge pclk) disable iff (!presetn)
    ce && dma_wr_en && !cpu_wr_data |=> !txe_r)
    else $error("dma write did not clear tx empty");
  a_tx_route: assert property (@(posedge pclk) disable iff (!presetn)
    !(tx_cpu_irq && tx_dma_req) && (tx_dma_req == (txe_r && dma_route_select && ctrl_r[0])))
    else $error("tx request routed wrong");
  a_mode_fault_flag_gate: assert property (@(posedge pclk) disable iff (!presetn)
    ce && !mode_fault_flag_r && !fen_r |=> !mode_fault_flag_r)
    else $error("mode fault set while disabled");
  a_mode_fault_flag_keep: assert property (@(posedge pclk) disable iff (!presetn)
    ce && mode_fault_flag_r && !(wr && hit_ctrl) |=> mode_fault_flag_r)
    else $error("mode fault lost");
  a_mode_fault_flag_master: assert property (@(posedge pclk) disable iff (!presetn)
    ce && en && mstr && fen_r && !ss_n_i |=> mode_fault_flag_r)
    else $error("master fault not flagged");
  a_ss_claim: assert property (@(posedge pclk) disable iff (!presetn)
    en && !mstr |-> ss_owned && !ss_gpio_free)
    else $error("slave left select pin free");
  a_rate_div: assert property (@(posedge pclk) disable iff (!presetn)
    ce && start && mstr && rate_r == 2'h1 ##1 ce [*4] |=> sck_ph_r && edge_r == 4'h1)
    else $error("divide by eight period wrong");
  a_rx_split: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !pwrite && hit_data |-> prdata[7:0] == rx_hold_r)
    else $error("data read not from rx holding");
  c_master_byte: cover property (@(posedge pclk) disable iff (!presetn)
    done && mstr);
  c_slave_byte: cover property (@(posedge pclk) disable iff (!presetn)
    done && !mstr);
  c_overflow: cover property (@(posedge pclk) disable iff (!presetn)
    done && rxf_r);
  c_fault: cover property (@(posedge pclk) disable iff (!presetn)
    fault && !mode_fault_flag_r);
endmodule : ssp_port
`default_nettype wire

//--- rtl/ssp_pkg.sv
// constants and register layout of the serial port tail
package ssp_pkg;
  // word indices; byte address is four times index
  localparam logic [5:0] IDX_CTRL = 6'h10;
  localparam logic [5:0] IDX_STAT = 6'h11;
  localparam logic [5:0] IDX_DATA = 6'h12;
  // control register bits
  localparam int C_RXIE = 7;
  localparam int C_DMA_ROUTE_SELECT = 6;
  localparam int C_MSTR = 5;
  localparam int C_CPOL = 4;
  localparam int C_CPHA = 3;
  localparam int C_EN = 1;
  localparam int C_TXIE = 0;
  localparam logic [7:0] CTRL_RST = 8'h28;
  // status and control register bits
  localparam int S_RXF = 7;
  localparam int S_ERRIE = 6;
  localparam int S_OVR = 5;
  localparam int S_MODE_FAULT_FLAG = 4;
  localparam int S_TXE = 3;
  localparam int S_FEN = 2;
  localparam int S_RHI = 1;
  localparam int S_RLO = 0;
  localparam logic [1:0] RATE_RST = 2'h0;
  // divisors per rate code
  localparam int DIV_00 = 2;
  localparam int DIV_01 = 8;
  localparam int DIV_10 = 32;
  localparam int DIV_11 = 128;
  localparam logic [6:0] HALF_00 = 7'(DIV_00 / 2);
  localparam logic [6:0] HALF_01 = 7'(DIV_01 / 2);
  localparam logic [6:0] HALF_10 = 7'(DIV_10 / 2);
  localparam logic [6:0] HALF_11 = 7'(DIV_11 / 2);
  localparam logic [3:0] LAST_EDGE = 4'hf;
  typedef enum logic [0:0] {
    SSP_IDLE = 1'b0,
    SSP_SHIFT = 1'b1
  } ssp_state_t;
endpackage : ssp_pkg

//--- test/ssp_remote.sv
// remote serial slave model that echoes back the byte it last received
`timescale 1ns/100ps
`default_nettype none
module ssp_remote #(
  parameter logic [7:0] INIT = 8'h3c
) (
  input wire logic sck,
  input wire logic en,
  input wire logic mosi,
  output logic miso,
  output logic [7:0] held
);
  logic [7:0] sh_r = INIT;
  logic miso_r = 1'b0;
  // clock idle low, phase one: drive on rising, sample on falling, msb first
  always @(posedge sck)
  begin
    if (en === 1'b1)
      miso_r <= sh_r[7];
  end
  // a released line shows the inverse of its last level
  assign miso = (en === 1'b1) ? miso_r : ~miso_r;
  always @(negedge sck)
  begin
    if (en === 1'b1)
      sh_r <= {sh_r[6:0], mosi};
  end
  assign held = sh_r;
endmodule : ssp_remote
`default_nettype wire

//--- test/spi_tx_flag_rate_and_data_reg_bench.sv
// self-checking bench of the serial port tail
`timescale 1ns/100ps
`default_nettype none
module spi_tx_flag_rate_and_data_reg_bench;
  localparam logic [7:0] A_CTRL = {ssp_pkg::IDX_CTRL, 2'b00};
  localparam logic [7:0] A_STAT = {ssp_pkg::IDX_STAT, 2'b00};
  localparam logic [7:0] A_DATA = {ssp_pkg::IDX_DATA, 2'b00};
  logic pclk, presetn, psel, penable, pwrite, dma_wr_en, ss_n_i;
  logic [7:0] paddr, dma_wdata, held;
  logic [31:0] pwdata, prdata, rd_q;
  logic pready, pslverr, err_q, tx_cpu_irq, tx_dma_req, sck_o, sck_oe, mosi_o, miso_i;
  logic ss_owned, ss_gpio_free, err_cpu_irq;
  int n_errors = 0;
  int samples_checked = 0;
  int divs [4] = '{ssp_pkg::DIV_00, ssp_pkg::DIV_01, ssp_pkg::DIV_10, ssp_pkg::DIV_11};
  ssp_port ssp_port_inst (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .dma_wr_en(dma_wr_en), .dma_wdata(dma_wdata),
    .dma_rd_en(1'b0), .dma_rdata(), .tx_cpu_irq(tx_cpu_irq), .tx_dma_req(tx_dma_req),
    .rx_cpu_irq(), .rx_dma_req(), .err_cpu_irq(err_cpu_irq), .sck_i(1'b0), .sck_o(sck_o),
    .sck_oe(sck_oe), .mosi_i(1'b0), .mosi_o(mosi_o), .mosi_oe(), .miso_i(miso_i),
    .miso_o(), .miso_oe(), .ss_n_i(ss_n_i), .ss_owned(ss_owned), .ss_gpio_free(ss_gpio_free));
  ssp_remote ssp_remote_inst (.sck(sck_o), .en(sck_oe), .mosi(mosi_o), .miso(miso_i),
    .held(held));
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // ==========================================
  // shared tasks
  task report_and_stop();
    if (n_errors == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : report_and_stop
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task tmo();
    n_errors++;
    report_and_stop();
  endtask : tmo
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 16)
      tmo();
    #1;
  endtask : apb
  task poll_stat(input int b);
    int i;
    for (i = 0; i < 1000; i++)
    begin
      apb(1'b0, A_STAT, 32'h0);
      if (rd_q[b] === 1'b1)
        break;
    end
    if (i == 1000)
      tmo();
  endtask : poll_stat
  task sck_half(output int n);
    logic s;
    int i;
    s = sck_o;
    for (i = 0; i < 400; i++)
    begin
      @(posedge pclk);
      #1;
      if (sck_o !== s)
        break;
    end
    if (i == 400)
      tmo();
    s = sck_o;
    for (n = 1; n < 400; n++)
    begin
      @(posedge pclk);
      #1;
      if (sck_o !== s)
        break;
    end
  endtask : sck_half
  // ==========================================
  // scenarios
  task sc_reset_and_unmapped();
    apb(1'b0, A_CTRL, 32'h0);
    chk(rd_q, {24'h0, ssp_pkg::CTRL_RST});
    apb(1'b0, A_STAT, 32'h0);
    chk(rd_q, 32'h08);
    apb(1'b1, 8'h4c, 32'hff);
    chk({31'h0, err_q}, 32'h1);
  endtask : sc_reset_and_unmapped
  task sc_cpu_transfer();
    apb(1'b1, A_CTRL, 32'h2b);
    chk({31'h0, tx_cpu_irq}, 32'h1);
    apb(1'b1, A_DATA, 32'ha5);
    chk({31'h0, tx_cpu_irq}, 32'h0);
    poll_stat(ssp_pkg::S_TXE);
    chk({31'h0, tx_cpu_irq}, 32'h1);
    poll_stat(ssp_pkg::S_RXF);
    apb(1'b0, A_DATA, 32'h0);
    chk(rd_q, 32'h3c);
    chk({24'h0, held}, 32'ha5);
  endtask : sc_cpu_transfer
  task sc_rates();
    int k, n;
    logic [7:0] prev;
    prev = 8'ha5;
    for (k = 0; k < 4; k++)
    begin
      apb(1'b1, A_STAT, 32'(k));
      apb(1'b1, A_DATA, 32'h50 + 32'(k));
      sck_half(n);
      chk(32'(n), 32'(divs[k] / 2));
      poll_stat(ssp_pkg::S_RXF);
      apb(1'b0, A_DATA, 32'h0);
      chk(rd_q, {24'h0, prev});
      prev = 8'h50 + 8'(k);
    end
    apb(1'b1, A_STAT, 32'h0);
  endtask : sc_rates
  task sc_dma();
    apb(1'b1, A_CTRL, 32'h6b);
    chk({30'h0, tx_cpu_irq, tx_dma_req}, 32'h1);
    @(posedge pclk);
    dma_wr_en <= 1'b1;
    dma_wdata <= 8'h77;
    @(posedge pclk);
    dma_wr_en <= 1'b0;
    #1;
    chk({31'h0, tx_dma_req}, 32'h0);
    poll_stat(ssp_pkg::S_TXE);
    chk({31'h0, tx_dma_req}, 32'h1);
    poll_stat(ssp_pkg::S_RXF);
    apb(1'b0, A_DATA, 32'h0);
    chk(rd_q, 32'h53);
    apb(1'b1, A_DATA, 32'h12);
    chk({31'h0, tx_dma_req}, 32'h0);
    poll_stat(ssp_pkg::S_RXF);
    apb(1'b0, A_DATA, 32'h0);
    chk(rd_q, 32'h77);
  endtask : sc_dma
  task sc_fault();
    apb(1'b1, A_CTRL, 32'h2a);
    @(posedge pclk);
    ss_n_i <= 1'b0;
    apb(1'b0, A_STAT, 32'h0);
    chk({27'h0, rd_q[4], 3'h0, ss_gpio_free}, 32'h1);
    @(posedge pclk);
    ss_n_i <= 1'b1;
    apb(1'b1, A_STAT, 32'h04);
    chk({31'h0, ss_owned}, 32'h1);
    @(posedge pclk);
    ss_n_i <= 1'b0;
    apb(1'b0, A_STAT, 32'h0);
    chk(rd_q & 32'h1c, 32'h1c);
    @(posedge pclk);
    ss_n_i <= 1'b1;
    apb(1'b1, A_STAT, 32'h40);
    chk({31'h0, err_cpu_irq}, 32'h1);
    apb(1'b0, A_STAT, 32'h0);
    chk(rd_q & 32'h54, 32'h50);
    apb(1'b1, A_CTRL, 32'h02);
    chk({29'h0, ss_owned, ss_gpio_free, err_cpu_irq}, 32'h4);
  endtask : sc_fault
  // ==========================================
  // main sequence
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    dma_wr_en = 1'b0;
    dma_wdata = 8'h00;
    ss_n_i = 1'b1;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    sc_reset_and_unmapped();
    sc_cpu_transfer();
    sc_rates();
    sc_dma();
    sc_fault();
    report_and_stop();
  end
endmodule : spi_tx_flag_rate_and_data_reg_bench
`default_nettype wire
